//--- design/epv_pkg.sv
// Shared constants and types for the code EPROM program/verify port
package epv_pkg;
	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int ARRAY_DEPTH = 8192;
	localparam int ENC_AW = 5;
	localparam int ENC_DEPTH = 32;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [12:0] LAST_ADDR = 13'h1FFF;

	// ------------------------------------------------------------
	// Timing: one ref_clk period stands for one osc_period
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_SETUP_PERIODS = 48;
	localparam int VPP_SETUP_US = 10;
	localparam int PULSE_WIDTH_US = 100;
	localparam int PULSE_GAP_US = 10;
	localparam int PULSE_REPEAT = 25;
	localparam int VPP_SETUP_CYC = (VPP_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_GAP_CYC = (PULSE_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_WIDTH_CYC = (PULSE_WIDTH_US * 1000) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Pin levels of ext_access_prog_voltage
	// ------------------------------------------------------------
	localparam logic [1:0] VPP_LVL_LOW = 2'h0;
	localparam logic [1:0] VPP_LVL_HIGH = 2'h1;
	localparam logic [1:0] VPP_LVL_PROG = 2'h2;

	// ------------------------------------------------------------
	// Signature locations and values (values arbitrary)
	// ------------------------------------------------------------
	localparam logic [12:0] SIG_MAKER_ADDR = 13'h0030;
	localparam logic [12:0] SIG_PART_ADDR = 13'h0031;
	localparam logic [7:0] SIG_MAKER_VAL = 8'hA5;
	localparam logic [7:0] SIG_PART_VAL = 8'h3C;

	// ------------------------------------------------------------
	// Programmer command codes
	// ------------------------------------------------------------
	localparam logic [2:0] OP_PROG_CODE = 3'h0;
	localparam logic [2:0] OP_PROG_TABLE = 3'h1;
	localparam logic [2:0] OP_LOCK1 = 3'h2;
	localparam logic [2:0] OP_LOCK2 = 3'h3;
	localparam logic [2:0] OP_VERIFY = 3'h4;
	localparam logic [2:0] OP_SIGNATURE = 3'h5;

	// Device-side decoded pin mode
	typedef enum logic [6:0] {
		MODE_NONE = 7'h01,
		MODE_PROG_CODE = 7'h02,
		MODE_PROG_TABLE = 7'h04,
		MODE_LOCK1 = 7'h08,
		MODE_LOCK2 = 7'h10,
		MODE_VERIFY = 7'h20,
		MODE_SIGNATURE = 7'h40
	} epv_mode_e;
endpackage

//--- design/epv_link_if.sv
// Pin-level link between the external programmer and the device
`timescale 1ns/10ps
interface epv_link_if;
	logic rst_pin;
	logic program_store_enable_n;
	logic latch_program_strobe;
	logic [1:0] ext_access_prog_voltage;
	logic [7:0] port1;
	logic [7:0] port2;
	logic port3_6;
	logic port3_7;
	logic [7:0] prog_p0_out;
	logic prog_p0_oe;
	logic [7:0] dev_p0_out;
	logic dev_p0_oe;
	logic [7:0] p0_level;

	// Port zero wire: external pull-ups give ones when nobody drives
	assign p0_level = dev_p0_oe ? dev_p0_out : (prog_p0_oe ? prog_p0_out : 8'hFF);

	modport device (
		input rst_pin, program_store_enable_n, latch_program_strobe,
		input ext_access_prog_voltage, port1, port2, port3_6, port3_7, p0_level,
		output dev_p0_out, dev_p0_oe
	);
	modport programmer (
		output rst_pin, program_store_enable_n, latch_program_strobe,
		output ext_access_prog_voltage, port1, port2, port3_6, port3_7,
		output prog_p0_out, prog_p0_oe,
		input p0_level
	);
endinterface

//--- design/epv_device.sv
// Device end: code EPROM array with program, lock, encrypt and verify logic
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps

// Notes on behaviour
// - Programmer keeps device clocked during programming
// - Address on port1 plus port2[4:0], data port0
// - Code program mode pin levels
// - Programming voltage only around the pulses
// - Voltage back at logic high before verify
// - Twenty-five 100 us low strobes per byte
// - Read back byte, then whole array
// - Verify: port2 bit7 low drives port zero
// - Verify data only while no lock programmed
// - Verify output is code XNOR table byte
// - Table program: port3 bit6 low, 32 entries
// - Lock program: port2 bit6 high, selects
// - Lock bits pulse-programmed, never read back
// - Address and data stable 48 periods
// - Enable before voltage, voltage 10 us margins
// - Data valid and release within 48 periods
// - Five address bits pick table byte
// - Lock1 blocks programming, both block verify
// - Signature mode returns maker and part
module epv_device (
	input wire logic ref_clk,
	input wire logic nrst,
	epv_link_if.device link,
	input wire logic uv_erase,
	output logic erase_busy,
	output logic [1:0] lock_bit_n
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int PIN_W = 31;
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_stb_r;
	logic [PIN_W-1:0] pin_stb_nxt;

	// Pins come from another chip; a bit counts once stages 2 and 3 agree
	assign pin_raw = {link.rst_pin, link.program_store_enable_n, link.latch_program_strobe,
		link.ext_access_prog_voltage, link.port1, link.port2, link.port3_6,
		link.port3_7, link.p0_level};

	always_comb begin
		pin_stb_nxt = (pin_s2_r & ~(pin_s2_r ^ pin_s3_r)) | (pin_stb_r & (pin_s2_r ^ pin_s3_r));
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_s3_r <= '0;
			pin_stb_r <= '0;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_stb_r <= pin_stb_nxt;
		end
	end

	logic rst_lvl, store_en_n_lvl, strobe_lvl, p2_7, p2_6, p3_6, p3_7;
	logic [1:0] vpp_lvl;
	logic [12:0] addr;
	logic [7:0] p0_in;

	// Address is port1 plus the low five port-two pins
	assign rst_lvl = pin_stb_r[30];
	assign store_en_n_lvl = pin_stb_r[29];
	assign strobe_lvl = pin_stb_r[28];
	assign vpp_lvl = pin_stb_r[27:26];
	assign addr = {pin_stb_r[14:10], pin_stb_r[25:18]};
	assign p2_7 = pin_stb_r[17];
	assign p2_6 = pin_stb_r[16];
	assign p3_6 = pin_stb_r[9];
	assign p3_7 = pin_stb_r[8];
	assign p0_in = pin_stb_r[7:0];

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	function automatic epv_pkg::epv_mode_e decode_mode(input logic rst, input logic store_en_n,
			input logic strobe_hi, input logic [1:0] vpp, input logic e7, input logic e6,
			input logic q6, input logic q7);
		logic base;
		base = rst & ~store_en_n;
		decode_mode = epv_pkg::MODE_NONE;
		if (base && e7 && vpp == epv_pkg::VPP_LVL_PROG) begin
			if (!e6 && q6 && q7)
				decode_mode = epv_pkg::MODE_PROG_CODE;
			else if (!e6 && !q6 && q7)
				decode_mode = epv_pkg::MODE_PROG_TABLE;
			else if (e6 && q6 && q7)
				decode_mode = epv_pkg::MODE_LOCK1;
			else if (e6 && !q6 && !q7)
				decode_mode = epv_pkg::MODE_LOCK2;
		end else if (base && strobe_hi && !e7 && !e6 && vpp == epv_pkg::VPP_LVL_HIGH) begin
			// Verify only with the pin back at logic high
			if (q6 && q7)
				decode_mode = epv_pkg::MODE_VERIFY;
			else if (!q6 && !q7)
				decode_mode = epv_pkg::MODE_SIGNATURE;
		end
	endfunction

	epv_pkg::epv_mode_e mode;
	epv_pkg::epv_mode_e prog_mode;
	assign mode = decode_mode(rst_lvl, store_en_n_lvl, strobe_lvl, vpp_lvl, p2_7, p2_6, p3_6,
		p3_7);
	// Program modes ignore the strobe level itself, it is the pulse
	assign prog_mode = decode_mode(rst_lvl, store_en_n_lvl, 1'b0, vpp_lvl, p2_7, p2_6, p3_6,
		p3_7);

	// ------------------------------------------------------------
	// Control state: erase sweep, locks, strobe edge
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_ERASE = 2'h1,
		ST_RUN = 2'h2
	} epv_state_e;

	epv_state_e state_r, state_nxt;
	logic [12:0] erase_cnt_r, erase_cnt_nxt;
	logic [1:0] lock_r, lock_nxt;
	logic strobe_prev_r;
	logic fall;
	logic code_we, table_we;

	// Blank part after power-up: sweep whole array to ones
	always_comb begin
		state_nxt = state_r;
		erase_cnt_nxt = erase_cnt_r;
		lock_nxt = lock_r;
		fall = strobe_prev_r & ~strobe_lvl;
		code_we = 1'b0;
		table_we = 1'b0;
		case (state_r)
			ST_ERASE: begin
				lock_nxt = 2'h0;
				erase_cnt_nxt = erase_cnt_r + 13'h0001;
				if (erase_cnt_r == epv_pkg::LAST_ADDR)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (uv_erase) begin
					state_nxt = ST_ERASE;
					erase_cnt_nxt = 13'h0000;
				end else if (fall) begin
					// Each falling strobe is one pulse; repeats are harmless
					case (prog_mode)
						epv_pkg::MODE_PROG_CODE: code_we = ~lock_r[0];
						epv_pkg::MODE_PROG_TABLE: table_we = ~lock_r[0];
						epv_pkg::MODE_LOCK1: lock_nxt[0] = 1'b1;
						epv_pkg::MODE_LOCK2: lock_nxt[1] = 1'b1;
						default: ; // Unknown pin mix: nothing changes
					endcase
				end
			end
			default: state_nxt = ST_ERASE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_ERASE;
			erase_cnt_r <= 13'h0000;
			lock_r <= 2'h0;
			strobe_prev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			erase_cnt_r <= erase_cnt_nxt;
			lock_r <= lock_nxt;
			strobe_prev_r <= strobe_lvl;
		end
	end

	// ------------------------------------------------------------
	// Storage: code array and encryption table
	// ------------------------------------------------------------
	logic [7:0] code_mem [epv_pkg::ARRAY_DEPTH];
	logic [7:0] enc_r [epv_pkg::ENC_DEPTH];
	logic [7:0] code_rd_r;
	logic [7:0] enc_rd_r;

	// EPROM cells only go from one to zero, so writes AND in the data
	always_ff @(posedge ref_clk) begin
		if (state_r == ST_ERASE)
			code_mem[erase_cnt_r] <= epv_pkg::ERASED_BYTE;
		else if (code_we)
			code_mem[addr] <= code_mem[addr] & p0_in;
		code_rd_r <= code_mem[addr];
	end

	// Table lives in flops; only 32 entries are addressed
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < epv_pkg::ENC_DEPTH; i++)
				enc_r[i] <= epv_pkg::ERASED_BYTE;
			enc_rd_r <= epv_pkg::ERASED_BYTE;
		end else begin
			for (int i = 0; i < epv_pkg::ENC_DEPTH; i++) begin
				if (state_r == ST_ERASE)
					enc_r[i] <= epv_pkg::ERASED_BYTE;
				else if (table_we && addr[4:0] == i[4:0])
					enc_r[i] <= enc_r[i] & p0_in;
			end
			enc_rd_r <= enc_r[addr[4:0]];
		end
	end

	// ------------------------------------------------------------
	// Verify output path
	// ------------------------------------------------------------
	logic [7:0] p0_out_r, p0_out_nxt;
	logic p0_oe_r, p0_oe_nxt;
	logic sig_r, code_r;
	logic [12:0] addr_d_r;

	// Read data lags the address by one cycle, so mode is delayed to match
	always_comb begin
		p0_oe_nxt = 1'b0;
		p0_out_nxt = epv_pkg::ERASED_BYTE;
		if (state_r == ST_RUN && code_r && lock_r == 2'h0) begin
			p0_oe_nxt = 1'b1;
			p0_out_nxt = ~(code_rd_r ^ enc_rd_r);
		end else if (state_r == ST_RUN && sig_r) begin
			p0_oe_nxt = 1'b1;
			if (addr_d_r == epv_pkg::SIG_MAKER_ADDR)
				p0_out_nxt = epv_pkg::SIG_MAKER_VAL;
			else if (addr_d_r == epv_pkg::SIG_PART_ADDR)
				p0_out_nxt = epv_pkg::SIG_PART_VAL;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			p0_out_r <= epv_pkg::ERASED_BYTE;
			p0_oe_r <= 1'b0;
			sig_r <= 1'b0;
			code_r <= 1'b0;
			addr_d_r <= 13'h0000;
		end else begin
			p0_out_r <= p0_out_nxt;
			p0_oe_r <= p0_oe_nxt;
			sig_r <= (mode == epv_pkg::MODE_SIGNATURE);
			code_r <= (mode == epv_pkg::MODE_VERIFY);
			addr_d_r <= addr;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic busy_r;
	logic [1:0] lock_n_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			busy_r <= 1'b1;
			lock_n_r <= 2'h3;
		end else begin
			busy_r <= (state_nxt == ST_ERASE);
			lock_n_r <= ~lock_nxt;
		end
	end

	assign link.dev_p0_out = p0_out_r;
	assign link.dev_p0_oe = p0_oe_r;
	assign erase_busy = busy_r;
	assign lock_bit_n = lock_n_r;
endmodule

//--- design/epv_programmer.sv
// Programmer end: sequences mode pins, voltage and strobe pulse trains
`timescale 1ns/10ps
module epv_programmer #(
	parameter int PULSE_WIDTH_CYC = epv_pkg::PULSE_WIDTH_CYC,
	parameter int PULSE_GAP_CYC = epv_pkg::PULSE_GAP_CYC
) (
	input wire logic ref_clk,
	input wire logic nrst,
	epv_link_if.programmer link,
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_op,
	input wire logic [12:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	output logic busy,
	output logic rd_valid,
	output logic [7:0] rd_data
);
	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		PS_IDLE = 7'h01,
		PS_SETUP = 7'h02,
		PS_VPP = 7'h04,
		PS_PULSE = 7'h08,
		PS_GAP = 7'h10,
		PS_HOLD = 7'h20,
		PS_READ = 7'h40
	} epv_pstate_e;

	epv_pstate_e st_r, st_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [4:0] npulse_r, npulse_nxt;
	logic [2:0] op_r, op_nxt;
	logic [12:0] addr_r, addr_nxt;
	logic [7:0] data_r, data_nxt;
	logic strobe_r, strobe_nxt;
	logic [1:0] vpp_r, vpp_nxt;
	logic en_r, en_nxt;
	logic p0_oe_r, p0_oe_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;
	logic [7:0] p0_s1_r, p0_s2_r, p0_s3_r, p0_stb_r;
	logic is_read;
	logic busy_r;

	assign is_read = (op_r == epv_pkg::OP_VERIFY) || (op_r == epv_pkg::OP_SIGNATURE);

	// Timed walk through setup, voltage, 25 pulses, hold
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r - 16'h0001;
		npulse_nxt = npulse_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		data_nxt = data_r;
		strobe_nxt = strobe_r;
		vpp_nxt = vpp_r;
		en_nxt = en_r;
		p0_oe_nxt = p0_oe_r;
		rd_valid_nxt = 1'b0;
		rd_data_nxt = rd_data_r;
		case (st_r)
			PS_IDLE: begin
				cnt_nxt = cnt_r;
				if (cmd_valid) begin
					op_nxt = cmd_op;
					addr_nxt = cmd_addr;
					data_nxt = cmd_data;
					cnt_nxt = 16'(epv_pkg::OSC_SETUP_PERIODS);
					st_nxt = PS_SETUP;
					// Reads drop the enable as read strobe, writes drive port zero
					if (cmd_op == epv_pkg::OP_VERIFY || cmd_op == epv_pkg::OP_SIGNATURE)
						en_nxt = 1'b0;
					else
						p0_oe_nxt = 1'b1;
				end
			end
			PS_SETUP: if (cnt_r == 16'h0001) begin
				// Address, data and enable settled for 48 periods
				if (is_read) begin
					rd_data_nxt = p0_stb_r;
					rd_valid_nxt = 1'b1;
					en_nxt = 1'b1;
					cnt_nxt = 16'(epv_pkg::OSC_SETUP_PERIODS);
					st_nxt = PS_READ;
				end else begin
					vpp_nxt = epv_pkg::VPP_LVL_PROG;
					cnt_nxt = 16'(epv_pkg::VPP_SETUP_CYC);
					npulse_nxt = 5'h00;
					st_nxt = PS_VPP;
				end
			end
			PS_VPP, PS_GAP: if (cnt_r == 16'h0001) begin
				if (npulse_r == 5'(epv_pkg::PULSE_REPEAT)) begin
					vpp_nxt = epv_pkg::VPP_LVL_HIGH;
					cnt_nxt = 16'(epv_pkg::OSC_SETUP_PERIODS);
					st_nxt = PS_HOLD;
				end else begin
					strobe_nxt = 1'b0;
					cnt_nxt = 16'(PULSE_WIDTH_CYC);
					npulse_nxt = npulse_r + 5'h01;
					st_nxt = PS_PULSE;
				end
			end
			PS_PULSE: if (cnt_r == 16'h0001) begin
				strobe_nxt = 1'b1;
				// Last pulse waits out the full voltage hold, others only the gap
				if (npulse_r == 5'(epv_pkg::PULSE_REPEAT))
					cnt_nxt = 16'(epv_pkg::VPP_SETUP_CYC);
				else
					cnt_nxt = 16'(PULSE_GAP_CYC);
				st_nxt = PS_GAP;
			end
			PS_HOLD, PS_READ: if (cnt_r == 16'h0001) begin
				// Port released only after the hold window
				p0_oe_nxt = 1'b0;
				st_nxt = PS_IDLE;
			end
			default: st_nxt = PS_IDLE;
		endcase
	end

	// Idle levels: reset high, store enable low, no known mode selected
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= PS_IDLE;
			cnt_r <= 16'h0000;
			npulse_r <= 5'h00;
			op_r <= epv_pkg::OP_PROG_CODE;
			addr_r <= 13'h0000;
			data_r <= 8'hFF;
			strobe_r <= 1'b1;
			vpp_r <= epv_pkg::VPP_LVL_HIGH;
			en_r <= 1'b1;
			p0_oe_r <= 1'b0;
			rd_valid_r <= 1'b0;
			rd_data_r <= 8'h00;
			busy_r <= 1'b0;
			p0_s1_r <= 8'hFF;
			p0_s2_r <= 8'hFF;
			p0_s3_r <= 8'hFF;
			p0_stb_r <= 8'hFF;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			npulse_r <= npulse_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			strobe_r <= strobe_nxt;
			vpp_r <= vpp_nxt;
			en_r <= en_nxt;
			p0_oe_r <= p0_oe_nxt;
			rd_valid_r <= rd_valid_nxt;
			rd_data_r <= rd_data_nxt;
			busy_r <= (st_nxt != PS_IDLE);
			p0_s1_r <= link.p0_level;
			p0_s2_r <= p0_s1_r;
			p0_s3_r <= p0_s2_r;
			p0_stb_r <= (p0_s2_r & ~(p0_s2_r ^ p0_s3_r)) | (p0_stb_r & (p0_s2_r ^ p0_s3_r));
		end
	end

	// ------------------------------------------------------------
	// Pin drive: mode selects per operation
	// ------------------------------------------------------------
	logic p2_6_r, p3_6_r, p3_7_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			p2_6_r <= 1'b0;
			p3_6_r <= 1'b1;
			p3_7_r <= 1'b1;
		end else if (st_r == PS_IDLE && cmd_valid) begin
			p2_6_r <= (cmd_op == epv_pkg::OP_LOCK1) || (cmd_op == epv_pkg::OP_LOCK2);
			p3_6_r <= (cmd_op == epv_pkg::OP_PROG_CODE) || (cmd_op == epv_pkg::OP_LOCK1) ||
				(cmd_op == epv_pkg::OP_VERIFY);
			p3_7_r <= (cmd_op != epv_pkg::OP_LOCK2) && (cmd_op != epv_pkg::OP_SIGNATURE);
		end
	end

	assign link.rst_pin = 1'b1;
	assign link.program_store_enable_n = 1'b0;
	assign link.latch_program_strobe = strobe_r;
	assign link.ext_access_prog_voltage = vpp_r;
	assign link.port1 = addr_r[7:0];
	assign link.port2 = {en_r, p2_6_r, 1'b0, addr_r[12:8]};
	assign link.port3_6 = p3_6_r;
	assign link.port3_7 = p3_7_r;
	assign link.prog_p0_out = data_r;
	assign link.prog_p0_oe = p0_oe_r;
	assign busy = busy_r;
	assign rd_valid = rd_valid_r;
	assign rd_data = rd_data_r;
endmodule

//--- verification/epv_link_checker.sv
// Concurrent checks on the pins between programmer and device
`timescale 1ns/10ps
module epv_link_checker #(
	parameter int PULSE_WIDTH_CYC = epv_pkg::PULSE_WIDTH_CYC
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic latch_program_strobe,
	input wire logic [1:0] ext_access_prog_voltage,
	input wire logic [7:0] port1,
	input wire logic [7:0] port2,
	input wire logic port3_6,
	input wire logic port3_7,
	input wire logic [7:0] prog_p0_out,
	input wire logic prog_p0_oe,
	input wire logic [7:0] dev_p0_out,
	input wire logic dev_p0_oe
);
	logic [25:0] pins;
	logic [25:0] pins_q;
	logic strobe_q;
	logic [1:0] vpp_q;
	logic [6:0] stab_cnt;
	logic [6:0] en_cnt;
	logic [10:0] rise_cnt;
	logic [10:0] vpp_cnt;
	logic [15:0] low_cnt;
	logic [4:0] pulse_cnt;
	logic vpp_on;
	logic fell_s;
	logic rose_s;
	logic vpp_rose;
	logic vpp_fell;
	logic settled;

	// ------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------
	// Edge and level decodes of strobe and voltage
	assign pins = {port1, port2, port3_6, port3_7, prog_p0_out};
	assign vpp_on = ext_access_prog_voltage == epv_pkg::VPP_LVL_PROG;
	assign fell_s = !latch_program_strobe && strobe_q;
	assign rose_s = latch_program_strobe && !strobe_q;
	assign vpp_rose = vpp_on && (vpp_q != epv_pkg::VPP_LVL_PROG);
	assign vpp_fell = !vpp_on && (vpp_q == epv_pkg::VPP_LVL_PROG);
	// Pins unchanged for a dozen cycles, so the far end has settled
	assign settled = (pins == pins_q) && (stab_cnt >= 7'h0C);

	// Stability, enable, rise and voltage counters saturate, so long idle stretches never wrap
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			strobe_q <= 1'b1;
			vpp_q <= epv_pkg::VPP_LVL_HIGH;
			pins_q <= '0;
			stab_cnt <= '0;
			en_cnt <= '0;
			rise_cnt <= '1; // No recent rise after reset
			vpp_cnt <= '0;
			low_cnt <= '0;
			pulse_cnt <= '0;
		end else begin
			strobe_q <= latch_program_strobe;
			vpp_q <= ext_access_prog_voltage;
			pins_q <= pins;
			stab_cnt <= (pins != pins_q) ? '0 : ((&stab_cnt) ? stab_cnt : stab_cnt + 7'h01);
			en_cnt <= !port2[7] ? '0 : ((&en_cnt) ? en_cnt : en_cnt + 7'h01);
			rise_cnt <= rose_s ? 11'h001 : ((&rise_cnt) ? rise_cnt : rise_cnt + 11'h001);
			vpp_cnt <= !vpp_on ? '0 : ((&vpp_cnt) ? vpp_cnt : vpp_cnt + 11'h001);
			low_cnt <= latch_program_strobe ? '0 : low_cnt + 16'h0001;
			pulse_cnt <= vpp_rose ? '0 : (fell_s ? pulse_cnt + 5'h01 : pulse_cnt);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	strobe_vpp_a: assert property (!latch_program_strobe |-> vpp_on)
		else $error("strobe low without programming voltage");
	pulse_width_a: assert property (rose_s |-> low_cnt == 16'(PULSE_WIDTH_CYC))
		else $error("strobe pulse width wrong");
	pulse_count_a: assert property (vpp_fell |-> pulse_cnt == 5'(epv_pkg::PULSE_REPEAT))
		else $error("pulse train length wrong");
	vpp_setup_a: assert property (fell_s |-> vpp_cnt >= 11'(epv_pkg::VPP_SETUP_CYC))
		else $error("voltage setup before strobe too short");
	vpp_hold_a: assert property (vpp_fell |-> rise_cnt >= 11'(epv_pkg::VPP_SETUP_CYC))
		else $error("voltage hold after strobe too short");
	enable_lead_a: assert property (vpp_rose |-> port2[7] && en_cnt >= 7'h30)
		else $error("enable not high long enough before voltage");
	addr_setup_a: assert property (fell_s |-> stab_cnt >= 7'h30)
		else $error("address or data setup too short");
	addr_hold_a: assert property (rise_cnt <= 11'h030 |-> pins == pins_q)
		else $error("address or data changed during hold");
	lock_select_a: assert property (!latch_program_strobe && port2[6] |-> port3_6 == port3_7)
		else $error("lock select levels invalid");
	table_select_a: assert property (!latch_program_strobe && !port2[6] && !port3_6 |-> port3_7)
		else $error("table program levels invalid");
	dev_release_a: assert property ($rose(port2[7]) |-> ##[0:48] !dev_p0_oe)
		else $error("device kept port zero after enable rose");
	sig_ready_a: assert property ($fell(port2[7]) && !port3_6 && !port3_7 |-> ##[1:48] dev_p0_oe)
		else $error("signature data not driven in time");
	sig_value_a: assert property (dev_p0_oe && settled && !port3_6 && !port3_7 &&
		{port2[4:0], port1} == epv_pkg::SIG_MAKER_ADDR |-> dev_p0_out == epv_pkg::SIG_MAKER_VAL)
		else $error("maker signature value wrong");
	drive_mode_a: assert property (dev_p0_oe && settled |-> !port2[7] && !port2[6] &&
		latch_program_strobe && ext_access_prog_voltage == epv_pkg::VPP_LVL_HIGH)
		else $error("device drove port zero outside read levels");
	no_fight_a: assert property (prog_p0_oe |-> !dev_p0_oe)
		else $error("both ends drive port zero");
endmodule

//--- verification/testbench.sv
// Self-checking bench: programmer and device joined over the pin link
`timescale 1ns/10ps
module testbench;
	localparam int PW = 20; // Short pulse keeps the run small
	logic ref_clk = 1'b0;
	logic nrst;
	logic uv_erase;
	logic cmd_valid;
	logic [2:0] cmd_op;
	logic [12:0] cmd_addr;
	logic [7:0] cmd_data;
	logic busy;
	logic rd_valid;
	logic erase_busy;
	logic [7:0] rd_data;
	logic [1:0] lock_bit_n;
	logic [12:0] addr_a;
	logic [7:0] data_d;
	logic [7:0] tab_t;
	logic [7:0] exp_q[$];
	int miscompares = 0;
	int comparisons = 0;
	int seed = 10;

	// ------------------------------------------------------------
	// Clock and instances
	// ------------------------------------------------------------
	// Free-running clock stands in for the oscillator
	always #5 ref_clk = ~ref_clk;

	epv_link_if epv_link_if_inst();
	epv_device epv_device_inst(.ref_clk(ref_clk), .nrst(nrst), .link(epv_link_if_inst),
		.uv_erase(uv_erase), .erase_busy(erase_busy), .lock_bit_n(lock_bit_n));
	// Short gaps as well; the voltage hold after the last pulse stays full length
	epv_programmer #(.PULSE_WIDTH_CYC(PW), .PULSE_GAP_CYC(PW)) epv_programmer_inst(
		.ref_clk(ref_clk), .nrst(nrst),
		.link(epv_link_if_inst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data));
	epv_link_checker #(.PULSE_WIDTH_CYC(PW)) epv_link_checker_inst(.ref_clk(ref_clk), .nrst(nrst),
		.latch_program_strobe(epv_link_if_inst.latch_program_strobe),
		.ext_access_prog_voltage(epv_link_if_inst.ext_access_prog_voltage),
		.port1(epv_link_if_inst.port1), .port2(epv_link_if_inst.port2),
		.port3_6(epv_link_if_inst.port3_6), .port3_7(epv_link_if_inst.port3_7),
		.prog_p0_out(epv_link_if_inst.prog_p0_out), .prog_p0_oe(epv_link_if_inst.prog_p0_oe),
		.dev_p0_out(epv_link_if_inst.dev_p0_out), .dev_p0_oe(epv_link_if_inst.dev_p0_oe));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		if (miscompares == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	// Bounded wait for busy or erase_busy to go low; a hang ends the run
	task automatic wait_low(input bit on_erase, input int lim);
		for (int n = 0; n < lim; n++) begin
			@(posedge ref_clk);
			if ((on_erase ? erase_busy : busy) === 1'b0) begin
				return;
			end
		end
		miscompares++;
		give_verdict();
	endtask

	// One command: offered only while idle, cmd_valid held a single edge
	task automatic issue(input logic [2:0] op, input logic [12:0] addr, input logic [7:0] data);
		wait_low(1'b0, 30000);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= addr;
		cmd_data <= data;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		wait_low(1'b0, 30000);
	endtask

	// Read: note the expected byte, then issue
	task automatic rd(input logic [2:0] op, input logic [12:0] addr, input logic [7:0] want);
		exp_q.push_back(want);
		issue(op, addr, 8'h00);
	endtask

	// ------------------------------------------------------------
	// Result watcher
	// ------------------------------------------------------------
	// An answer with no note pending compares against unknown and fails
	always @(posedge ref_clk) begin
		if (rd_valid === 1'b1) begin
			check(rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		uv_erase = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 3'h0;
		cmd_addr = 13'h0000;
		cmd_data = 8'h00;
		addr_a = 13'($random(seed));
		data_d = 8'($random(seed)) & 8'hFE; // Keep one bit cleared so the write shows
		tab_t = 8'($random(seed));
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		wait_low(1'b1, 9000);
		rd(epv_pkg::OP_VERIFY, addr_a, epv_pkg::ERASED_BYTE);
		rd(epv_pkg::OP_SIGNATURE, epv_pkg::SIG_MAKER_ADDR, epv_pkg::SIG_MAKER_VAL);
		rd(epv_pkg::OP_SIGNATURE, epv_pkg::SIG_PART_ADDR, epv_pkg::SIG_PART_VAL);
		issue(epv_pkg::OP_PROG_CODE, addr_a, data_d);
		rd(epv_pkg::OP_VERIFY, addr_a, data_d);
		issue(epv_pkg::OP_PROG_TABLE, {8'h00, addr_a[4:0]}, tab_t);
		rd(epv_pkg::OP_VERIFY, addr_a, ~(data_d ^ tab_t));
		rd(epv_pkg::OP_VERIFY, addr_a ^ 13'h0100, tab_t);
		rd(epv_pkg::OP_VERIFY, addr_a ^ 13'h0001, epv_pkg::ERASED_BYTE);
		issue(epv_pkg::OP_LOCK1, 13'h0000, 8'h00);
		check({6'h00, lock_bit_n}, 8'h02);
		rd(epv_pkg::OP_VERIFY, addr_a, epv_pkg::ERASED_BYTE);
		rd(epv_pkg::OP_SIGNATURE, epv_pkg::SIG_MAKER_ADDR, epv_pkg::SIG_MAKER_VAL);
		issue(epv_pkg::OP_LOCK2, 13'h0000, 8'h00);
		check({6'h00, lock_bit_n}, 8'h00);
		rd(epv_pkg::OP_VERIFY, addr_a ^ 13'h0100, epv_pkg::ERASED_BYTE);
		// Erase in mid-run clears locks, table and array again
		uv_erase <= 1'b1;
		@(posedge ref_clk);
		uv_erase <= 1'b0;
		wait_low(1'b1, 9000);
		check({6'h00, lock_bit_n}, 8'h03);
		rd(epv_pkg::OP_VERIFY, addr_a, epv_pkg::ERASED_BYTE);
		rd(epv_pkg::OP_VERIFY, addr_a ^ 13'h0100, epv_pkg::ERASED_BYTE);
		check(8'(exp_q.size()), 8'h00);
		give_verdict();
	end
endmodule
